// File: src/eif_pkg.sv
package eif_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] EIF_OFF_CTRL = 8'h00;
  localparam logic [7:0] EIF_OFF_TIMER_STATUS_REG = 8'h04;
  localparam logic [7:0] EIF_OFF_ISTAT = 8'h08;
  localparam logic [7:0] EIF_OFF_IMASK = 8'h0c;
  // ----------------------------------------
  // field positions in timer_irq_control
  // ----------------------------------------
  localparam int EIF_BIT_TF0 = 5;
  localparam int EIF_BIT_TR0 = 4;
  localparam int EIF_BIT_IE1 = 3;
  localparam int EIF_BIT_IT1 = 2;
  localparam int EIF_BIT_IE0 = 1;
  localparam int EIF_BIT_IT0 = 0;
  // field position in timer_status_reg
  localparam int EIF_BIT_T0OE = 0;
  // ----------------------------------------
  // event layout of status and mask
  // ----------------------------------------
  localparam int EIF_NEVT = 3;
  localparam int EIF_EVT_T0 = 0;
  localparam int EIF_EVT_X0 = 1;
  localparam int EIF_EVT_X1 = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_BIT = 1'b0;
  localparam logic [2:0] EIF_RST_MASK = 3'h0;
  localparam logic [2:0] EIF_RST_STAT = 3'h0;
  localparam logic [7:0] EIF_RST_RDATA = 8'h00;
  localparam logic [2:0] EIF_RST_SYNC = 3'h7;
  localparam logic EIF_RST_LVL = 1'b1;
  typedef enum logic [1:0] {EIF_PHASE_IDLE, EIF_PHASE_SEEN} eif_phase_t;
endpackage : eif_pkg

// File: src/eif_evt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface eif_evt_if;
  logic [2:0] evt;
  logic rd_clr;
  logic [2:0] status;
  modport src (output evt, output rd_clr, input status);
  modport sink (input evt, input rd_clr, output status);
endinterface : eif_evt_if
`default_nettype wire

// File: src/eif_pin_det.sv
`timescale 1ns/1ns
`default_nettype none
module eif_pin_det (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pin_n,
  output logic level_low,
  output logic fall
);
  import eif_pkg::*;
  logic [2:0] sync;
  logic lvl;
  // ----------------------------------------
  // three-stage sync, a change counts when stages two and three agree
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync <= EIF_RST_SYNC;
    end else begin
      sync <= {sync[1:0], pin_n};
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lvl <= EIF_RST_LVL;
    end else if (sync[1] == sync[2]) begin
      lvl <= sync[2];
    end
  end
  assign level_low = ~lvl;
  assign fall = lvl & (sync[1] == sync[2]) & ~sync[2];
endmodule : eif_pin_det
`default_nettype wire

// File: src/eif_irq_bank.sv
`timescale 1ns/1ns
`default_nettype none
module eif_irq_bank (
  input wire logic sys_clk,
  input wire logic rstn,
  eif_evt_if.sink evt_bus
);
  import eif_pkg::*;
  logic [2:0] stat;
  // ----------------------------------------
  // sticky status, a new event beats the read clear
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat <= EIF_RST_STAT;
    end else if (evt_bus.rd_clr) begin
      stat <= evt_bus.evt;
    end else begin
      stat <= stat | evt_bus.evt;
    end
  end
  assign evt_bus.status = stat;
endmodule : eif_irq_bank
`default_nettype wire

// File: src/eif_ctrl.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Function
// - timer 0 overflow sets the timer 0 overflow flag
// - overflow does not set the flag while toggle-output enable is set
// - overflow flag clears on processor vector or software write of zero
// - software run bit starts and stops timer 0
// - edge on external interrupt 1 sets its flag, cleared when processed
// - software type bit selects edge or level trigger for interrupt 1
// - edge on external interrupt 0 sets its flag, cleared when processed
// - software type bit selects edge or level trigger for interrupt 0
module eif_ctrl (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ext_irq0_n,
  input wire logic ext_irq1_n,
  input wire logic t0_overflow,
  input wire logic t0_vector_ack,
  input wire logic ext_irq0_ack,
  input wire logic ext_irq1_ack,
  output logic t0_run_bit,
  output logic t0_toggle_out_enable,
  output logic t0_irq_req,
  output logic ext_irq0_req,
  output logic ext_irq1_req,
  output logic irq
);
  import eif_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic t0_overflow_flag;
  logic ext_irq0_edge_flag;
  logic ext_irq1_edge_flag;
  logic ext_irq0_type_bit;
  logic ext_irq1_type_bit;
  logic [2:0] irq_mask;
  logic x0_low;
  logic x0_fall;
  logic x1_low;
  logic x1_fall;
  logic wr_ctrl;
  logic t0_set;
  logic x0_set;
  logic x1_set;
  logic [7:0] next_rdata;
  eif_evt_if evt_bus ();

  assign wr_ctrl = wr_en && (addr == EIF_OFF_CTRL);

  // ----------------------------------------
  // pin detectors
  // ----------------------------------------
  eif_pin_det u_det0 (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_n(ext_irq0_n),
    .level_low(x0_low),
    .fall(x0_fall)
  );
  eif_pin_det u_det1 (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_n(ext_irq1_n),
    .level_low(x1_low),
    .fall(x1_fall)
  );

  // ----------------------------------------
  // software control bits
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      t0_run_bit <= RST_BIT;
    end else if (wr_ctrl) begin
      t0_run_bit <= wdata[EIF_BIT_TR0];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_irq0_type_bit <= RST_BIT;
      ext_irq1_type_bit <= RST_BIT;
    end else if (wr_ctrl) begin
      ext_irq0_type_bit <= wdata[EIF_BIT_IT0];
      ext_irq1_type_bit <= wdata[EIF_BIT_IT1];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      t0_toggle_out_enable <= RST_BIT;
    end else if (wr_en && (addr == EIF_OFF_TIMER_STATUS_REG)) begin
      t0_toggle_out_enable <= wdata[EIF_BIT_T0OE];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= EIF_RST_MASK;
    end else if (wr_en && (addr == EIF_OFF_IMASK)) begin
      irq_mask <= wdata[2:0];
    end
  end

  // ----------------------------------------
  // timer 0 overflow flag
  // ----------------------------------------
  assign t0_set = t0_overflow & ~t0_toggle_out_enable;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      t0_overflow_flag <= RST_BIT;
    end else if (t0_set) begin
      t0_overflow_flag <= 1'b1;
    end else if (t0_vector_ack || (wr_ctrl && !wdata[EIF_BIT_TF0])) begin
      t0_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // external interrupt flags
  // ----------------------------------------
  // level mode keeps the flag up while the pin is low and drops it by itself
  // once the pin is high again, with or without an ack
  assign x0_set = ext_irq0_type_bit ? x0_fall : x0_low;
  assign x1_set = ext_irq1_type_bit ? x1_fall : x1_low;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_irq0_edge_flag <= RST_BIT;
    end else if (x0_set) begin
      ext_irq0_edge_flag <= 1'b1;
    end else if (ext_irq0_ack || !ext_irq0_type_bit) begin
      ext_irq0_edge_flag <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_irq1_edge_flag <= RST_BIT;
    end else if (x1_set) begin
      ext_irq1_edge_flag <= 1'b1;
    end else if (ext_irq1_ack || !ext_irq1_type_bit) begin
      ext_irq1_edge_flag <= 1'b0;
    end
  end
  assign t0_irq_req = t0_overflow_flag;
  assign ext_irq0_req = ext_irq0_edge_flag;
  assign ext_irq1_req = ext_irq1_edge_flag;

  // ----------------------------------------
  // sticky status and interrupt line
  // ----------------------------------------
  // status records rising of each flag, not the level, so level mode
  // gives one event per assertion
  assign evt_bus.evt[EIF_EVT_T0] = t0_set & ~t0_overflow_flag;
  assign evt_bus.evt[EIF_EVT_X0] = x0_set & ~ext_irq0_edge_flag;
  assign evt_bus.evt[EIF_EVT_X1] = x1_set & ~ext_irq1_edge_flag;
  assign evt_bus.rd_clr = rd_en && (addr == EIF_OFF_ISTAT);
  eif_irq_bank u_bank (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .evt_bus(evt_bus)
  );
  assign irq = |(evt_bus.status & irq_mask);

  // ----------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      EIF_OFF_CTRL: begin
        next_rdata[EIF_BIT_TF0] = t0_overflow_flag;
        next_rdata[EIF_BIT_TR0] = t0_run_bit;
        next_rdata[EIF_BIT_IE1] = ext_irq1_edge_flag;
        next_rdata[EIF_BIT_IT1] = ext_irq1_type_bit;
        next_rdata[EIF_BIT_IE0] = ext_irq0_edge_flag;
        next_rdata[EIF_BIT_IT0] = ext_irq0_type_bit;
      end
      EIF_OFF_TIMER_STATUS_REG: begin
        next_rdata[EIF_BIT_T0OE] = t0_toggle_out_enable;
      end
      EIF_OFF_ISTAT: begin
        next_rdata[2:0] = evt_bus.status;
      end
      EIF_OFF_IMASK: begin
        next_rdata[2:0] = irq_mask;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= EIF_RST_RDATA;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= EIF_RST_RDATA;
    end
  end
endmodule : eif_ctrl
`default_nettype wire

// File: verification/eif_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module eif_ctrl_monitor import eif_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic ext_irq0_n,
  input wire logic ext_irq1_n,
  input wire logic t0_overflow,
  input wire logic t0_vector_ack,
  input wire logic ext_irq0_ack,
  input wire logic ext_irq1_ack,
  input wire logic t0_run_bit,
  input wire logic t0_toggle_out_enable,
  input wire logic t0_irq_req,
  input wire logic ext_irq0_req,
  input wire logic ext_irq1_req,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic it0, it1;
  logic [2:0] mask_m;
  // type bits and mask are not ports of the DUT, so mirror them from the bus
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {it1, it0} <= 2'h0;
      mask_m <= 3'h0;
    end else if (wr_en && addr == EIF_OFF_CTRL) begin
      {it1, it0} <= {wdata[EIF_BIT_IT1], wdata[EIF_BIT_IT0]};
    end else if (wr_en && addr == EIF_OFF_IMASK) begin
      mask_m <= wdata[2:0];
    end
  end
  a_ovf_sets: assert property (t0_overflow && !t0_toggle_out_enable |=> t0_irq_req)
    else $error("overflow did not set flag");
  a_ovf_blocked: assert property (
    t0_overflow && t0_toggle_out_enable && !t0_irq_req |=> !t0_irq_req)
    else $error("flag set with toggle enable");
  a_vector_clears: assert property (t0_vector_ack && !t0_overflow |=> !t0_irq_req)
    else $error("vector ack did not clear flag");
  a_sw_clear: assert property (
    wr_en && addr == EIF_OFF_CTRL && !wdata[EIF_BIT_TF0] && !t0_overflow |=> !t0_irq_req)
    else $error("write of zero kept flag");
  a_run_write: assert property (
    wr_en && addr == EIF_OFF_CTRL |=> t0_run_bit == $past(wdata[EIF_BIT_TR0]))
    else $error("run bit wrong");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_edge_holds: assert property (
    it1 && ext_irq1_req && !wr_en && !ext_irq1_ack |=> ext_irq1_req)
    else $error("edge flag dropped without ack");
  a_ack_clears: assert property (
    (it0 && ext_irq0_n)[*5] ##0 (ext_irq0_ack && !wr_en) |=> !ext_irq0_req)
    else $error("ack did not clear edge flag");
  a_level_set: assert property (
    (!it1 && !ext_irq1_n && !wr_en)[*6] |-> ext_irq1_req)
    else $error("low level not flagged");
  a_level_clr: assert property (
    (!it0 && ext_irq0_n && !wr_en)[*6] |-> !ext_irq0_req)
    else $error("level flag kept with pin high");
  a_irq_masked: assert property (irq |-> mask_m != 3'h0)
    else $error("irq with all events masked");
  c_vector: cover property (t0_irq_req && t0_vector_ack);
  c_irq: cover property (irq);
  c_level: cover property (ext_irq1_req && !it1);
endmodule : eif_ctrl_monitor
bind eif_ctrl eif_ctrl_monitor u_mon (.*);
`default_nettype wire

// File: verification/eif_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module eif_core_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] ack_en,
  input wire logic [2:0] req,
  output logic [2:0] ack
);
  // one-cycle ack then a gap, so a request that the ack clears is never acked twice
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 3'h0;
    end else begin
      ack <= ack_en & req & ~ack;
    end
  end
endmodule : eif_core_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import eif_pkg::*;
  logic sys_clk, rstn, wr_en, rd_en, ovf, run, toe, irq;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] ack_en, ack, req;
  logic [1:0] pin_n;
  int n_mismatch, n_checks, cyc;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  eif_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ext_irq0_n(pin_n[0]), .ext_irq1_n(pin_n[1]),
    .t0_overflow(ovf), .t0_vector_ack(ack[0]), .ext_irq0_ack(ack[1]), .ext_irq1_ack(ack[2]),
    .t0_run_bit(run), .t0_toggle_out_enable(toe), .t0_irq_req(req[0]),
    .ext_irq0_req(req[1]), .ext_irq1_req(req[2]), .irq(irq));
  eif_core_model core (.sys_clk(sys_clk), .rstn(rstn), .ack_en(ack_en), .req(req), .ack(ack));
  task complete_run;
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task ovf_pulse;
    @(posedge sys_clk) ovf <= 1'b1;
    @(posedge sys_clk) ovf <= 1'b0;
    #1;
  endtask : ovf_pulse
  // bounded run: the whole sequence needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    {rstn, wr_en, rd_en, ovf} = 4'h0;
    {addr, wdata, ack_en} = 19'h0;
    pin_n = 2'h3;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 5; k++) rd(8'(k * 4), 8'h00);
    wr(EIF_OFF_CTRL, 8'h10);
    rd(EIF_OFF_CTRL, 8'h10);
    chk({7'h0, run}, 8'h01);
    ovf_pulse();
    chk({5'h0, req}, 8'h01);
    rd(EIF_OFF_CTRL, 8'h30);
    wr(EIF_OFF_CTRL, 8'h30);
    chk({5'h0, req}, 8'h01);
    wr(EIF_OFF_CTRL, 8'h10);
    chk({5'h0, req}, 8'h00);
    ovf_pulse();
    @(posedge sys_clk) ack_en <= 3'h1;
    tick(3);
    chk({5'h0, req}, 8'h00);
    wr(EIF_OFF_TIMER_STATUS_REG, 8'h01);
    chk({7'h0, toe}, 8'h01);
    ovf_pulse();
    chk({5'h0, req}, 8'h00);
    wr(EIF_OFF_TIMER_STATUS_REG, 8'h00);
    rd(EIF_OFF_ISTAT, 8'h01);
    wr(EIF_OFF_IMASK, 8'h06);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) ack_en <= 3'h0;
      wr(EIF_OFF_CTRL, 8'h05);
      chk({7'h0, run}, 8'h00);
      @(posedge sys_clk) pin_n[i] <= 1'b0;
      tick(2);
      @(posedge sys_clk) pin_n[i] <= 1'b1;
      tick(6);
      chk({5'h0, req}, 8'h02 << i);
      chk({7'h0, irq}, 8'h01);
      rd(EIF_OFF_ISTAT, 8'h02 << i);
      chk({7'h0, irq}, 8'h00);
      @(posedge sys_clk) ack_en <= 3'h2 << i;
      tick(3);
      chk({5'h0, req}, 8'h00);
      wr(EIF_OFF_CTRL, 8'h00);
      @(posedge sys_clk) pin_n[i] <= 1'b0;
      tick(6);
      chk({5'h0, req}, 8'h02 << i);
      @(posedge sys_clk) pin_n[i] <= 1'b1;
      tick(6);
      chk({5'h0, req}, 8'h00);
      // the level event stays sticky, so drain it before the next pin
      rd(EIF_OFF_ISTAT, 8'h02 << i);
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
